/* File: rtl/prefetch_ctrl.sv */
// Anticipatory read pre-fetch controller
`timescale 1ns/1ps
`include "prefetch_cfg.svh"
module prefetch_ctrl
  import prefetch_pkg::*;
#(
  parameter int CW = `PF_COUNT_W,
  parameter int AW = `PF_LBA_W,
  parameter bit DEFER_ERRORS = 1'b1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic read_valid,
  input wire logic [AW-1:0] read_lba,
  input wire logic [CW-1:0] read_len,
  input wire logic length_scale_flag,
  input wire logic [CW-1:0] disable_len,
  input wire logic [CW-1:0] min_prefetch,
  input wire logic [CW-1:0] max_prefetch,
  input wire logic [CW-1:0] max_ceiling,
  input wire logic [AW-1:0] last_lba,
  input wire logic cmd_pending,
  input wire logic media_ready,
  input wire logic media_done,
  input wire logic media_error,
  input wire logic media_error_fatal,
  output logic fetch_req,
  output logic [AW-1:0] fetch_lba,
  output logic busy,
  output logic end_pulse,
  output logic abandoned,
  output logic [CW-1:0] fetched_count,
  output logic err_now,
  output logic err_deferred
);
  typedef struct packed {
    pf_state_e st;
    logic [AW-1:0] lba;
    logic [CW-1:0] done_cnt;
    logic [CW-1:0] min_cnt;
    logic [CW-1:0] max_cnt;
    logic no_abandon;
    logic req;
    logic end_p;
    logic aband;
    logic [CW-1:0] fetched;
    logic err_n;
    logic err_d;
    logic [AW-1:0] next_lba;
    logic [CW-1:0] next_len;
    logic bsy;
  } pf_s;

  pf_s s_reg;
  pf_s s_next;
  logic [CW-1:0] min_calc;
  logic [CW-1:0] max_calc;
  logic [CW-1:0] max_bound;
  logic [CW-1:0] min_bound;
  logic [AW-1:0] after_read;
  logic allow;

  // Settings arrive already assembled from the high and low page bytes
  pf_count_calc #(.CW(CW)) u_min (
    .scale(length_scale_flag),
    .setting(min_prefetch),
    .req_len(s_reg.next_len),
    .ceiling(max_ceiling),
    .clamp_en(1'b0),
    .count(min_calc)
  );

  pf_count_calc #(.CW(CW)) u_max (
    .scale(length_scale_flag),
    .setting(max_prefetch),
    .req_len(s_reg.next_len),
    .ceiling(max_ceiling),
    .clamp_en(1'b1),
    .count(max_calc)
  );

  pf_bound #(.CW(CW), .AW(AW)) u_bmax (
    .start_lba(s_reg.next_lba),
    .last_lba(last_lba),
    .want(max_calc),
    .allowed(max_bound)
  );

  pf_bound #(.CW(CW), .AW(AW)) u_bmin (
    .start_lba(s_reg.next_lba),
    .last_lba(last_lba),
    .want(min_calc),
    .allowed(min_bound)
  );

  assign after_read = read_lba + {{(AW-CW){1'b0}}, read_len};
  assign allow = (disable_len != `PF_RST_COUNT) && (read_len <= disable_len);

  always_comb begin
    s_next = s_reg;
    s_next.end_p = 1'b0;
    s_next.err_n = 1'b0;
    s_next.err_d = 1'b0;
    case (s_reg.st)
      ST_IDLE: begin
        if (read_valid && allow) begin
          s_next.next_lba = after_read;
          s_next.next_len = read_len;
          s_next.st = ST_PLAN;
        end
      end
      ST_PLAN: begin
        s_next.lba = s_reg.next_lba;
        s_next.max_cnt = max_bound;
        s_next.min_cnt = (min_bound > max_bound) ? max_bound : min_bound;
        s_next.no_abandon = (min_prefetch == max_prefetch);
        s_next.done_cnt = `PF_RST_COUNT;
        s_next.aband = 1'b0;
        if (max_bound == `PF_RST_COUNT) begin
          s_next.end_p = 1'b1;
          s_next.fetched = `PF_RST_COUNT;
          s_next.st = ST_IDLE;
        end else begin
          s_next.req = 1'b1;
          s_next.st = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (media_ready) begin
          s_next.req = 1'b0;
          s_next.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (media_done || media_error) begin
          s_next.done_cnt = s_reg.done_cnt + `PF_RST_ONE;
          s_next.lba = s_reg.lba + {{(AW-1){1'b0}}, 1'b1};
          if (media_error && media_error_fatal) begin
            s_next.err_n = !DEFER_ERRORS;
            s_next.err_d = DEFER_ERRORS;
            s_next.aband = 1'b1;
            s_next.end_p = 1'b1;
            s_next.fetched = s_reg.done_cnt;
            s_next.st = ST_IDLE;
          end else if (s_next.done_cnt >= s_reg.max_cnt) begin
            s_next.end_p = 1'b1;
            s_next.fetched = s_next.done_cnt;
            s_next.st = ST_IDLE;
          end else if (cmd_pending && !s_reg.no_abandon &&
                       (s_next.done_cnt > s_reg.min_cnt)) begin
            s_next.end_p = 1'b1;
            s_next.aband = 1'b1;
            s_next.fetched = s_next.done_cnt;
            s_next.st = ST_IDLE;
          end else begin
            s_next.req = 1'b1;
            s_next.st = ST_FETCH;
          end
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
    // A newer read while fetching only overwrites next_lba and next_len; the running fetch goes on unchanged
    if (s_reg.st != ST_IDLE && s_reg.st != ST_PLAN && read_valid) begin
      s_next.next_lba = after_read;
      s_next.next_len = read_len;
    end
    // Registered so the busy output comes straight from a flop
    s_next.bsy = (s_next.st != ST_IDLE);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign fetch_req = s_reg.req;
  assign fetch_lba = s_reg.lba;
  assign busy = s_reg.bsy;
  assign end_pulse = s_reg.end_p;
  assign abandoned = s_reg.aband;
  assign fetched_count = s_reg.fetched;
  assign err_now = s_reg.err_n;
  assign err_deferred = s_reg.err_d;

  a_disable_zero: assert property (@(posedge ref_clk) disable iff (srst)
    (s_reg.st == ST_IDLE && read_valid && disable_len == '0) |=> s_reg.st == ST_IDLE)
    else $error("pre-fetch started with zero disable length");

  a_long_skip: assert property (@(posedge ref_clk) disable iff (srst)
    (s_reg.st == ST_IDLE && read_valid && read_len > disable_len) |=> s_reg.st == ST_IDLE)
    else $error("pre-fetch started on long read");

  a_start_addr: assert property (@(posedge ref_clk) disable iff (srst)
    (s_reg.st == ST_IDLE && read_valid && allow) |=> s_reg.next_lba == $past(after_read))
    else $error("pre-fetch start address wrong");

  a_media_end: assert property (@(posedge ref_clk) disable iff (srst)
    fetch_req |-> fetch_lba <= last_lba)
    else $error("fetch beyond medium end");

  a_max_limit: assert property (@(posedge ref_clk) disable iff (srst)
    end_pulse |-> fetched_count <= s_reg.max_cnt)
    else $error("fetched more than maximum");

  a_min_kept: assert property (@(posedge ref_clk) disable iff (srst)
    (end_pulse && abandoned && !$past(media_error)) |-> fetched_count > s_reg.min_cnt)
    else $error("abandoned below minimum");

  a_no_abandon: assert property (@(posedge ref_clk) disable iff (srst)
    (end_pulse && s_reg.no_abandon && !$past(media_error)) |-> !abandoned)
    else $error("abandoned with equal minimum and maximum");

  sequence s_plan;
    s_reg.st == ST_PLAN;
  endsequence
  a_ceiling: assert property (@(posedge ref_clk) disable iff (srst)
    s_plan |=> s_reg.max_cnt <= $past(max_ceiling))
    else $error("maximum above ceiling");

  a_end_pulse: assert property (@(posedge ref_clk) disable iff (srst)
    end_pulse |=> !end_pulse)
    else $error("end pulse longer than one cycle");

  a_err_route: assert property (@(posedge ref_clk) disable iff (srst)
    (err_now || err_deferred) |-> $past(media_error && media_error_fatal))
    else $error("non-fatal pre-fetch error reported");

  // Per-block steps of the fetch loop
  sequence s_block_ok;
    s_reg.st == ST_WAIT && media_done && !media_error;
  endsequence

  sequence s_fatal;
    s_reg.st == ST_WAIT && media_error && media_error_fatal;
  endsequence

  a_start_req: assert property (@(posedge ref_clk) disable iff (srst)
    s_plan ##0 (max_bound != '0) |=> fetch_req && fetch_lba == $past(s_reg.next_lba))
    else $error("first fetch request missing or misplaced");

  a_zero_plan: assert property (@(posedge ref_clk) disable iff (srst)
    s_plan ##0 (max_bound == '0) |=> end_pulse && fetched_count == '0 && !busy)
    else $error("empty pre-fetch did not end at once");

  a_req_hold: assert property (@(posedge ref_clk) disable iff (srst)
    (fetch_req && !media_ready) |=> fetch_req && $stable(fetch_lba))
    else $error("fetch request dropped before acceptance");

  a_lba_step: assert property (@(posedge ref_clk) disable iff (srst)
    s_block_ok |=> fetch_lba == $past(fetch_lba) + {{(AW-1){1'b0}}, 1'b1})
    else $error("fetch address did not advance");

  a_below_min: assert property (@(posedge ref_clk) disable iff (srst)
    s_block_ok ##0 (s_reg.done_cnt < s_reg.min_cnt) |=> !abandoned)
    else $error("abandoned before minimum reached");

  a_max_stop: assert property (@(posedge ref_clk) disable iff (srst)
    s_block_ok ##0 (s_reg.done_cnt + {{(CW-1){1'b0}}, 1'b1} == s_reg.max_cnt)
    |=> end_pulse && !abandoned)
    else $error("pre-fetch did not stop at maximum");

  a_fatal_stop: assert property (@(posedge ref_clk) disable iff (srst)
    s_fatal |=> end_pulse && abandoned && !busy)
    else $error("fatal fetch error did not end pre-fetch");

  a_abandon_wait: assert property (@(posedge ref_clk) disable iff (srst)
    (end_pulse && abandoned && !$past(media_error)) |-> $past(cmd_pending))
    else $error("abandoned with no command waiting");

  a_one_report: assert property (@(posedge ref_clk) disable iff (srst)
    !(err_now && err_deferred))
    else $error("error reported both now and deferred");

  a_result_hold: assert property (@(posedge ref_clk) disable iff (srst)
    (s_reg.st == ST_FETCH) |=> $stable(fetched_count))
    else $error("fetched count changed mid pre-fetch");

  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (srst)
    !busy |-> !fetch_req)
    else $error("fetch request while idle");
endmodule : prefetch_ctrl

/* File: rtl/prefetch_cfg.svh */
// Constants of the read pre-fetch controller
`ifndef PREFETCH_CFG_SVH
`define PREFETCH_CFG_SVH
`define PF_SETTING_W 16
`define PF_COUNT_W 16
`define PF_LBA_W 32
`define PF_SET_MSB_BYTE 8
`define PF_RST_COUNT 16'h0000
`define PF_RST_LBA 32'h0000_0000
`define PF_RST_ONE 16'h0001
`endif

/* File: rtl/prefetch_pkg.sv */
// Types of the read pre-fetch controller
package prefetch_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PLAN = 2'b01,
    ST_FETCH = 2'b10,
    ST_WAIT = 2'b11
  } pf_state_e;

  typedef enum logic [1:0] {
    END_NONE = 2'b00,
    END_DONE = 2'b01,
    END_ABANDON = 2'b10,
    END_ERROR = 2'b11
  } pf_end_e;
endpackage : prefetch_pkg

/* File: rtl/pf_count_calc.sv */
// Scaled and clamped pre-fetch count computation
`timescale 1ns/1ps
`include "prefetch_cfg.svh"
module pf_count_calc #(
  parameter int CW = `PF_COUNT_W
) (
  input wire logic scale,
  input wire logic [CW-1:0] setting,
  input wire logic [CW-1:0] req_len,
  input wire logic [CW-1:0] ceiling,
  input wire logic clamp_en,
  output logic [CW-1:0] count
);
  logic [2*CW-1:0] prod;
  logic [CW-1:0] sat;

  always_comb begin
    prod = {{CW{1'b0}}, setting} * {{CW{1'b0}}, req_len};
    // Saturate instead of wrapping when the product overflows
    if (!scale) begin
      sat = setting;
    end else if (|prod[2*CW-1:CW]) begin
      sat = {CW{1'b1}};
    end else begin
      sat = prod[CW-1:0];
    end
    if (clamp_en && (sat > ceiling)) begin
      count = ceiling;
    end else begin
      count = sat;
    end
  end
endmodule : pf_count_calc

/* File: rtl/pf_bound.sv */
// Limits a fetch span to the end of the medium
`timescale 1ns/1ps
`include "prefetch_cfg.svh"
module pf_bound #(
  parameter int CW = `PF_COUNT_W,
  parameter int AW = `PF_LBA_W
) (
  input wire logic [AW-1:0] start_lba,
  input wire logic [AW-1:0] last_lba,
  input wire logic [CW-1:0] want,
  output logic [CW-1:0] allowed
);
  logic [AW:0] room;

  always_comb begin
    if (start_lba > last_lba) begin
      room = '0;
    end else begin
      room = {1'b0, last_lba} - {1'b0, start_lba} + {{AW{1'b0}}, 1'b1};
    end
    if (room < {{(AW+1-CW){1'b0}}, want}) begin
      allowed = room[CW-1:0];
    end else begin
      allowed = want;
    end
  end
endmodule : pf_bound

/* File: test/media_model.sv */
// Media engine model that serves one block per fetch request
`timescale 1ns/1ps
module media_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic busy,
  input wire logic fetch_req,
  input wire logic slow,
  input wire logic [15:0] err_blk,
  input wire logic err_fatal,
  output logic media_ready,
  output logic media_done,
  output logic media_error,
  output logic media_error_fatal
);
  logic tick_reg;
  logic pend_reg;
  logic [15:0] n_reg;
  // Slow mode accepts only every other cycle
  assign media_ready = fetch_req && (tick_reg || !slow);
  always_ff @(posedge ref_clk) begin
    tick_reg <= srst ? 1'b0 : !tick_reg;
    pend_reg <= !srst && fetch_req && media_ready;
    media_done <= 1'b0;
    media_error <= 1'b0;
    media_error_fatal <= 1'b0;
    if (pend_reg) begin
      n_reg <= n_reg + 16'h0001;
      if (n_reg + 16'h0001 == err_blk) begin
        media_error <= 1'b1;
        media_error_fatal <= err_fatal;
      end else begin
        media_done <= 1'b1;
      end
    end
    if (srst || !busy) begin
      n_reg <= 16'h0000;
    end
  end
endmodule : media_model

/* File: test/prefetch_ctrl_tb.sv */
// Directed bench of the read pre-fetch controller
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR %0t: got %0h exp %0h", $time, (a), (b)); end end
module prefetch_ctrl_tb;
  logic ref_clk = 1'b0, srst = 1'b1, read_valid = 1'b0, length_scale_flag = 1'b0;
  logic cmd_pending = 1'b0, slow = 1'b0, err_fatal = 1'b0, got = 1'b0;
  logic [31:0] read_lba = 32'h0000_0000, last_lba = 32'hFFFF_FFFF;
  logic [31:0] fetch_lba, first;
  logic [15:0] read_len = 16'h0000, dis = 16'h0000, mn = 16'h0000;
  logic [15:0] mx = 16'h0000, ceil = 16'h0000, err_blk = 16'h0000;
  logic [15:0] fetched_count;
  logic media_ready, media_done, media_error, media_error_fatal;
  logic fetch_req, busy, end_pulse, abandoned, err_now, err_deferred;
  int n_mismatch = 0, n_checks = 0, n_now = 0, n_def = 0;
  prefetch_ctrl prefetch_ctrl_i (.ref_clk(ref_clk), .srst(srst), .read_valid(read_valid),
    .read_lba(read_lba), .read_len(read_len), .length_scale_flag(length_scale_flag),
    .disable_len(dis), .min_prefetch(mn), .max_prefetch(mx), .max_ceiling(ceil),
    .last_lba(last_lba), .cmd_pending(cmd_pending), .media_ready(media_ready),
    .media_done(media_done), .media_error(media_error),
    .media_error_fatal(media_error_fatal), .fetch_req(fetch_req), .fetch_lba(fetch_lba),
    .busy(busy), .end_pulse(end_pulse), .abandoned(abandoned),
    .fetched_count(fetched_count), .err_now(err_now), .err_deferred(err_deferred));
  media_model media_model_i (.ref_clk(ref_clk), .srst(srst), .busy(busy),
    .fetch_req(fetch_req), .slow(slow), .err_blk(err_blk), .err_fatal(err_fatal),
    .media_ready(media_ready), .media_done(media_done), .media_error(media_error),
    .media_error_fatal(media_error_fatal));
  always #4 ref_clk = !ref_clk;
  always @(posedge ref_clk) begin
    if (fetch_req && media_ready && !got) begin
      got <= 1'b1;
      first <= fetch_lba;
    end
    if (err_now) n_now++;
    if (err_deferred) n_def++;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic cfg(input logic f, input logic [15:0] d, l, h, c);
    @(negedge ref_clk);
    length_scale_flag = f;
    dis = d;
    mn = l;
    mx = h;
    ceil = c;
  endtask : cfg
  task automatic issue(input logic [31:0] lba, input logic [15:0] len);
    @(negedge ref_clk);
    got = 1'b0;
    read_lba = lba;
    read_len = len;
    read_valid = 1'b1;
    @(negedge ref_clk);
    read_valid = 1'b0;
  endtask : issue
  task automatic rd(input logic [31:0] lba, input logic [15:0] len, n, input logic ab);
    int t;
    t = 0;
    issue(lba, len);
    while (end_pulse !== 1'b1 && t < 3000) begin
      @(negedge ref_clk);
      t++;
    end
    `CHK(fetched_count, n)
    `CHK(abandoned, ab)
    `CHK(got, n != 16'h0000)
    if (n != 16'h0000) `CHK(first, lba + len)
    @(negedge ref_clk);
    `CHK(end_pulse, 1'b0)
  endtask : rd
  task automatic nostart(input logic [15:0] len);
    issue(32'h0000_0010, len);
    repeat (4) begin
      `CHK(busy, 1'b0)
      @(negedge ref_clk);
    end
  endtask : nostart
  initial begin
    repeat (20) @(negedge ref_clk);
    srst = 1'b0;
    cfg(1'b0, 16'h0008, 16'h0002, 16'h0005, 16'hFFFF);
    rd(32'h0000_0064, 16'h0004, 16'h0005, 1'b0);
    nostart(16'h0009);
    cfg(1'b0, 16'h0000, 16'h0002, 16'h0005, 16'hFFFF);
    nostart(16'h0000);
    cfg(1'b1, 16'h0008, 16'h0001, 16'h0002, 16'hFFFF);
    rd(32'h0000_0200, 16'h0003, 16'h0006, 1'b0);
    cfg(1'b1, 16'h0008, 16'h0001, 16'h0002, 16'h0004);
    rd(32'h0000_0300, 16'h0003, 16'h0004, 1'b0);
    cfg(1'b1, 16'h0008, 16'h0001, 16'h8001, 16'h0006);
    rd(32'h0000_0400, 16'h0002, 16'h0006, 1'b0);
    cmd_pending = 1'b1;
    cfg(1'b0, 16'h0008, 16'h0002, 16'h0006, 16'hFFFF);
    rd(32'h0000_0500, 16'h0004, 16'h0003, 1'b1);
    cfg(1'b0, 16'h0008, 16'h0004, 16'h0004, 16'hFFFF);
    rd(32'h0000_0600, 16'h0004, 16'h0004, 1'b0);
    cmd_pending = 1'b0;
    last_lba = 32'h0000_006A;
    cfg(1'b0, 16'h0008, 16'h0002, 16'h0005, 16'hFFFF);
    rd(32'h0000_0064, 16'h0004, 16'h0003, 1'b0);
    last_lba = 32'hFFFF_FFFF;
    slow = 1'b1;
    err_blk = 16'h0002;
    rd(32'h0000_0700, 16'h0004, 16'h0005, 1'b0);
    `CHK(n_now + n_def, 0)
    err_fatal = 1'b1;
    rd(32'h0000_0800, 16'h0004, 16'h0001, 1'b1);
    `CHK(n_def, 1)
    `CHK(n_now, 0)
    cfg(1'b1, 16'h0008, 16'h0002, 16'h0005, 16'hFFFF);
    rd(32'h0000_0900, 16'h0000, 16'h0000, 1'b0);
    stop_test();
  end
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule : prefetch_ctrl_tb
